// ---- verilog/afhp_parser.sv ----
// Header and text-chunk parser with an AHB-Lite register slave.
// Assumes byte_i is synchronous to clk_i and held until taken.
module afhp_parser
  import afhp_pkg::*;
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         arst_n_i,
  // Byte stream
  input  wire logic [7:0]   byte_i,
  input  wire logic         byte_valid_i,
  output logic              byte_ready_o,
  // Decoded fields
  output afhp_fields_s      fields_o,
  output afhp_stb_s         field_stb_o,
  output afhp_stb_s         fields_valid_o,
  output logic [7:0]        text_byte_o,
  output logic              text_valid_o,
  output logic              text_end_o,
  output logic              parse_err_o,
  output logic              parse_done_o,
  // AHB-Lite slave
  input  wire logic         hsel_i,
  input  wire logic [31:0]  haddr_i,
  input  wire logic [1:0]   htrans_i,
  input  wire logic         hwrite_i,
  input  wire logic [2:0]   hsize_i,
  input  wire logic [31:0]  hwdata_i,
  input  wire logic         hready_i,
  output logic [31:0]       hrdata_o,
  output logic              hreadyout_o,
  output logic              hresp_o
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ****************************************************************
  // State
  // ****************************************************************
  afhp_regs_s q;
  afhp_regs_s n;
  logic       acc;
  logic       last;
  logic       restart;
  logic [3:0] flen;
  logic [63:0] shn;

  always_comb begin
    case (q.st)
      ST_KEY, ST_CKEY:   flen = LEN_KEY;
      ST_HSIZE, ST_CSIZE: flen = LEN_SIZE;
      ST_VER:            flen = LEN_VER;
      ST_TC:             flen = LEN_TC;
      ST_META:           flen = LEN_META;
      default:           flen = LEN_ONE;
    endcase
  end

  assign acc  = byte_valid_i & q.rdy;
  assign last = (q.idx == flen - 4'h1);
  assign shn  = {q.sh[55:0], byte_i};
  assign restart = q.wr_pend & (q.wr_addr == REG_CTRL) & hwdata_i[1];

  always_comb begin
    n         = q;
    n.stb     = '0;
    n.txt_v   = 1'b0;
    n.txt_end = 1'b0;
    if (acc) begin
      n.sh  = shn;
      n.idx = last ? 4'h0 : q.idx + 4'h1;
      case (q.st)
        ST_KEY: begin
          if (last) begin
            n.st = (shn == HDR_KEYWORD) ? ST_HSIZE : ST_ERR;
          end
        end
        ST_HSIZE: begin
          if (last) begin
            n.f.hdr_size = shn;
            n.stb.size   = 1'b1;
            n.rem = (shn > HDR_FIXED_BYTES) ? shn - HDR_FIXED_BYTES : '0;
            n.st  = ST_VER;
          end
        end
        ST_VER: begin
          if (last) begin
            n.f.version = shn[31:0];
            n.stb.ver   = 1'b1;
            n.st        = ST_TC;
          end
        end
        ST_TC: begin
          if (last) begin
            if (shn[39:38] == REF_CODE_RSVD) begin
              n.st = ST_ERR;
            end else begin
              n.f.reference_rate_code = shn[39:38];
              n.f.sample_count_stamp  = shn[31:0];
              case (shn[39:38])
                2'h0:    n.f.rate_hz = RATE_HZ_0;
                2'h1:    n.f.rate_hz = RATE_HZ_1;
                default: n.f.rate_hz = RATE_HZ_2;
              endcase
              n.stb.tc = 1'b1;
              n.st     = ST_RATE;
            end
          end
        end
        ST_RATE: begin
          n.f.timecode_rate_code = byte_i[3:0];
          n.f.tc_rate_rsvd       = byte_i[3];
          n.stb.rate             = 1'b1;
          n.st                   = ST_META;
        end
        ST_META: begin
          if (last) begin
            n.f.variable_rate       = shn[0];
            n.f.peak_rate_smoothing = shn[1];
            n.f.navi_embedded       = shn[2];
            n.f.core_present        = shn[3];
            n.f.ext_present         = shn[4];
            n.stb.meta              = 1'b1;
            n.st                    = ST_PRES;
          end
        end
        ST_PRES: begin
          n.f.presentation_count = byte_i;
          n.stb.pres             = 1'b1;
          n.st                   = ST_EXT;
        end
        ST_EXT: begin
          n.f.extension_count_field = byte_i;
          n.f.extension_substream_total =
            q.f.ext_present ? {1'b0, byte_i} + 9'h001 : 9'h000;
          n.stb.ext = 1'b1;
          n.st      = (q.rem == '0) ? ST_CKEY : ST_HSKIP;
        end
        ST_HSKIP, ST_CSKIP: begin
          n.rem = q.rem - 64'h1;
          if (q.rem == 64'h1) begin
            n.st = ST_CKEY;
          end
        end
        ST_CKEY: begin
          if (last) begin
            n.match = (shn == TEXT_KEYWORD);
            n.st    = ST_CSIZE;
          end
        end
        ST_CSIZE: begin
          if (last) begin
            n.rem = shn;
            if (shn == '0) begin
              n.st = q.match ? ST_DONE : ST_CKEY;
            end else begin
              n.st = q.match ? ST_TEXT : ST_CSKIP;
            end
          end
        end
        ST_TEXT: begin
          n.rem = q.rem - 64'h1;
          if (byte_i == 8'h00) begin
            n.txt_end = 1'b1;
          end else begin
            n.txt   = byte_i;
            n.txt_v = 1'b1;
          end
          if (q.rem == 64'h1) begin
            n.st = ST_DONE;
          end else if (byte_i == 8'h00) begin
            n.st = ST_TSKIP;
          end
        end
        ST_TSKIP: begin
          n.rem = q.rem - 64'h1;
          if (q.rem == 64'h1) begin
            n.st = ST_DONE;
          end
        end
        default: begin
          n.st = q.st;
        end
      endcase
    end
    n.err  = (n.st == ST_ERR);
    n.done = (n.st == ST_DONE);
    n.vld  = n.err ? '0 : (q.vld | n.stb);
    if (n.err) begin
      n.stb = '0;
    end
    // Bus: register write data phase
    if (q.wr_pend && (q.wr_addr == REG_CTRL)) begin
      n.en = hwdata_i[0];
    end
    if (restart) begin
      n.st    = ST_KEY;
      n.idx   = '0;
      n.f     = '0;
      n.vld   = '0;
      n.stb   = '0;
      n.err   = 1'b0;
      n.done  = 1'b0;
      n.match = 1'b0;
    end
    n.rdy = n.en & (n.st != ST_DONE) & (n.st != ST_ERR);
    // Bus: address phase decode, read data at once
    n.wr_pend = 1'b0;
    n.hready  = 1'b1;
    if (hsel_i && hready_i && htrans_i[1]) begin
      n.wr_pend = hwrite_i;
      n.wr_addr = haddr_i[7:0];
      case (haddr_i[7:0])
        REG_CTRL:   n.hrdata = {31'h0, q.en};
        REG_STATUS: n.hrdata = {18'h0, STAMP_FRAME_IDX, 3'h0, q.vld, q.err, q.done};
        REG_VER:    n.hrdata = q.f.version;
        REG_STAMP:  n.hrdata = q.f.sample_count_stamp;
        REG_RATE:   n.hrdata = {4'h0, q.f.variable_rate, q.f.peak_rate_smoothing,
                                q.f.navi_embedded, q.f.core_present, q.f.ext_present,
                                q.f.tc_rate_rsvd, q.f.timecode_rate_code,
                                q.f.reference_rate_code, q.f.rate_hz};
        REG_COUNT:  n.hrdata = {15'h0, q.f.extension_substream_total,
                                q.f.presentation_count};
        REG_HSIZE:  n.hrdata = q.f.hdr_size[31:0];
        default:    n.hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q        <= '0;
      q.st     <= ST_KEY;
      q.en     <= CTRL_EN_RST;
      q.hready <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign byte_ready_o   = q.rdy;
  assign fields_o       = q.f;
  assign field_stb_o    = q.stb;
  assign fields_valid_o = q.vld;
  assign text_byte_o    = q.txt;
  assign text_valid_o   = q.txt_v;
  assign text_end_o     = q.txt_end;
  assign parse_err_o    = q.err;
  assign parse_done_o   = q.done;
  assign hrdata_o       = q.hrdata;
  assign hreadyout_o    = q.hready;
  assign hresp_o        = 1'b0;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence key_last_bad_s;
    (q.st == ST_KEY) && acc && last && (shn != HDR_KEYWORD) && !restart;
  endsequence
  sequence cskip_end_s;
    (q.st == ST_CSKIP) && acc && (q.rem == 64'h1) && !restart;
  endsequence

  key_check_a: assert property (key_last_bad_s |=> parse_err_o ##0 !byte_ready_o)
    else $error("bad keyword not flagged");
  err_novalid_a: assert property (parse_err_o |-> fields_valid_o == '0)
    else $error("fields valid during error");
  rate_map_a: assert property (fields_valid_o.tc |->
    (fields_o.reference_rate_code == 2'h0 && fields_o.rate_hz == 16'h7D00) ||
    (fields_o.reference_rate_code == 2'h1 && fields_o.rate_hz == 16'hAC44) ||
    (fields_o.reference_rate_code == 2'h2 && fields_o.rate_hz == 16'hBB80))
    else $error("rate mapping wrong");
  ext_total_a: assert property (fields_valid_o.ext |->
    fields_o.extension_substream_total == (fields_o.ext_present ?
      {1'b0, fields_o.extension_count_field} + 9'h001 : 9'h000))
    else $error("extension total wrong");
  nibble_only_a: assert property (field_stb_o.rate |->
    fields_o.timecode_rate_code == $past(byte_i[3:0]))
    else $error("rate code nibble wrong");
  msb_first_a: assert property (field_stb_o.ver |->
    fields_o.version[7:0] == $past(byte_i) && fields_o.version[15:8] == $past(q.sh[7:0]))
    else $error("version not msb first");
  chunk_skip_a: assert property (cskip_end_s |=> q.st == ST_CKEY)
    else $error("skip did not reach keyword");
  text_nonzero_a: assert property (text_valid_o |-> text_byte_o != 8'h00 && !text_end_o)
    else $error("terminator emitted as text");
  tc_split_a: assert property (field_stb_o.tc |->
    fields_o.sample_count_stamp[7:0] == $past(byte_i) &&
    fields_o.reference_rate_code != REF_CODE_RSVD)
    else $error("time code split wrong");

endmodule

// ---- shared/afhp_pkg.sv ----
// Constants and types of the audio file header parser.
// Assumes one clock domain and a byte source that follows the chunk layout.
package afhp_pkg;

  // ****************************************************************
  // Keywords (values arbitrary, not any real keyword)
  // ****************************************************************
  localparam logic [63:0] HDR_KEYWORD  = 64'h4846_5041_5248_4431;
  localparam logic [63:0] TEXT_KEYWORD = 64'h4846_5041_5458_5431;

  // ****************************************************************
  // Field lengths in bytes and layout
  // ****************************************************************
  localparam logic [3:0]  LEN_KEY  = 4'h8;
  localparam logic [3:0]  LEN_SIZE = 4'h8;
  localparam logic [3:0]  LEN_VER  = 4'h4;
  localparam logic [3:0]  LEN_TC   = 4'h5;
  localparam logic [3:0]  LEN_ONE  = 4'h1;
  localparam logic [3:0]  LEN_META = 4'h2;
  localparam logic [63:0] HDR_FIXED_BYTES = 64'h0000_0000_0000_000E;
  localparam logic [1:0]  REF_CODE_RSVD   = 2'h3;
  localparam logic [15:0] RATE_HZ_0 = 16'h7D00;
  localparam logic [15:0] RATE_HZ_1 = 16'hAC44;
  localparam logic [15:0] RATE_HZ_2 = 16'hBB80;
  localparam logic [1:0]  STAMP_FRAME_IDX = 2'h2;

  // ****************************************************************
  // Register map and reset values
  // ****************************************************************
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_VER    = 8'h08;
  localparam logic [7:0] REG_STAMP  = 8'h0C;
  localparam logic [7:0] REG_RATE   = 8'h10;
  localparam logic [7:0] REG_COUNT  = 8'h14;
  localparam logic [7:0] REG_HSIZE  = 8'h18;
  localparam logic       CTRL_EN_RST = 1'b1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_KEY, ST_HSIZE, ST_VER, ST_TC, ST_RATE, ST_META, ST_PRES, ST_EXT,
    ST_HSKIP, ST_CKEY, ST_CSIZE, ST_CSKIP, ST_TEXT, ST_TSKIP, ST_DONE, ST_ERR
  } afhp_state_e;

  // Strobe / valid bit order
  typedef struct packed {
    logic size;
    logic ver;
    logic tc;
    logic rate;
    logic meta;
    logic pres;
    logic ext;
  } afhp_stb_s;

  typedef struct packed {
    logic [63:0] hdr_size;
    logic [31:0] version;
    logic [1:0]  reference_rate_code;
    logic [15:0] rate_hz;
    logic [31:0] sample_count_stamp;
    logic [3:0]  timecode_rate_code;
    logic        tc_rate_rsvd;
    logic        variable_rate;
    logic        peak_rate_smoothing;
    logic        navi_embedded;
    logic        core_present;
    logic        ext_present;
    logic [7:0]  presentation_count;
    logic [7:0]  extension_count_field;
    logic [8:0]  extension_substream_total;
  } afhp_fields_s;

  typedef struct packed {
    afhp_state_e  st;
    logic [3:0]   idx;
    logic [63:0]  sh;
    logic [63:0]  rem;
    logic         match;
    afhp_fields_s f;
    afhp_stb_s    stb;
    afhp_stb_s    vld;
    logic         err;
    logic         done;
    logic         rdy;
    logic [7:0]   txt;
    logic         txt_v;
    logic         txt_end;
    logic         en;
    logic         wr_pend;
    logic [7:0]   wr_addr;
    logic [31:0]  hrdata;
    logic         hready;
  } afhp_regs_s;

endpackage

// ---- verif/afhp_src.sv ----
// Byte source model standing in for a stored audio file.
// Assumes the bench fills q in file order and calls flush before a restart.
module afhp_src (
  // Clock
  input  wire logic  clk_i,
  // Byte stream
  input  wire logic  byte_ready_i,
  output logic [7:0] byte_o,
  output logic       byte_valid_o
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [7:0] q[$];
  logic       slow;
  logic       gap_q;
  logic       vld_q;
  logic [7:0] dat_q;

  assign byte_o       = dat_q;
  assign byte_valid_o = vld_q;

  initial begin
    slow  = 1'b0;
    gap_q = 1'b0;
    vld_q = 1'b0;
    dat_q = 8'h00;
  end

  // Drop queued bytes and release the line
  task automatic flush();
    q.delete();
    vld_q <= 1'b0;
  endtask

  // ****
  // Byte pump, stalls every other cycle when slow
  // ****
  // file order kept, byte held until taken
  always @(posedge clk_i) begin
    gap_q <= ~gap_q;
    if (!vld_q || byte_ready_i) begin
      vld_q <= 1'b0;
      dat_q <= ~dat_q;
      if (q.size() != 0 && !(slow && gap_q)) begin
        vld_q <= 1'b1;
        dat_q <= q.pop_front();
      end
    end
  end
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the audio file header parser.
// Assumes afhp_pkg, the parser and the byte source model are compiled first.
module tb
  import afhp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // stamp from frame count, rate and video rate
  localparam logic [31:0] T_STAMP = 32'(64'd90000 * 64'd48000 / 64'd25);
  localparam logic [31:0] T_VER   = 32'h0102_0304;

  logic         clk_i;
  logic         arst_n_i;
  logic [7:0]   byte_w;
  logic         valid_w;
  logic         ready_w;
  afhp_fields_s fld;
  afhp_stb_s    stb;
  afhp_stb_s    fvld;
  afhp_stb_s    stb_acc;
  logic [7:0]   tbyte;
  logic         tvalid;
  logic         tend;
  logic         err;
  logic         done;
  logic         hsel;
  logic [31:0]  haddr;
  logic [1:0]   htrans;
  logic         hwrite;
  logic [31:0]  hwdata;
  logic [31:0]  hrdata;
  logic         hready;
  logic         hresp;
  logic         clr;
  logic [15:0]  txt;
  logic [31:0]  rd;
  int           n_end;
  int           bad_count;
  int           n_checks;

  afhp_src afhp_src_inst (
    .clk_i       (clk_i),
    .byte_ready_i(ready_w),
    .byte_o      (byte_w),
    .byte_valid_o(valid_w)
  );

  afhp_parser afhp_parser_inst (
    .clk_i         (clk_i),
    .arst_n_i      (arst_n_i),
    .byte_i        (byte_w),
    .byte_valid_i  (valid_w),
    .byte_ready_o  (ready_w),
    .fields_o      (fld),
    .field_stb_o   (stb),
    .fields_valid_o(fvld),
    .text_byte_o   (tbyte),
    .text_valid_o  (tvalid),
    .text_end_o    (tend),
    .parse_err_o   (err),
    .parse_done_o  (done),
    .hsel_i        (hsel),
    .haddr_i       (haddr),
    .htrans_i      (htrans),
    .hwrite_i      (hwrite),
    .hsize_i       (3'h2),
    .hwdata_i      (hwdata),
    .hready_i      (hready),
    .hrdata_o      (hrdata),
    .hreadyout_o   (hready),
    .hresp_o       (hresp)
  );

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // ****
  // Output monitor
  // ****
  always @(posedge clk_i) begin
    stb_acc <= clr ? '0 : (stb_acc | stb);
    txt     <= clr ? '0 : ((tvalid === 1'b1) ? {txt[7:0], tbyte} : txt);
    n_end   <= clr ? 0 : n_end + int'(tend === 1'b1);
  end

  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_i);
    while (hready !== 1'b1) @(posedge clk_i);
    r = hrdata;
  endtask

  task automatic put(input logic [63:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) afhp_src_inst.q.push_back(v[i*8 +: 8]);
  endtask

  // header first, size 16, two zero pad bytes
  task automatic hdr(input logic [63:0] k, input logic [39:0] tc, input logic [7:0] rt,
                     input logic [15:0] md);
    put(k, 8);
    put(64'h10, 8);
    put(64'(T_VER), 4);
    put(64'(tc), 5);
    put(64'(rt), 1);
    put(64'(md), 2);
    put(64'h0103, 2);
    put(64'h0, 2);
  endtask

  task automatic restart(input logic [31:0] c);
    afhp_src_inst.flush();
    bus(1'b1, 32'(REG_CTRL), c, rd);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
  endtask

  // ****
  // Scenarios
  // ****
  task automatic good_file();
    afhp_src_inst.slow = 1'b1;
    hdr(HDR_KEYWORD, {2'h2, 6'h3F, T_STAMP}, 8'hF5, 16'hFFFF);
    put(64'h1122_3344_5566_7788, 8);
    put(64'h4, 8);
    put(64'h0, 4);
    put(TEXT_KEYWORD, 8);
    put(64'h8, 8);
    put(64'h4142_0000_0000_0000, 8);
    repeat (600) if (done !== 1'b1) @(posedge clk_i);
    chk(fld.version, T_VER);
    chk(fld.reference_rate_code, 2'h2);
    chk(fld.rate_hz, RATE_HZ_2);
    chk(fld.sample_count_stamp, T_STAMP);
    chk({fld.timecode_rate_code, fld.tc_rate_rsvd}, {4'h5, 1'b0});
    chk({fld.variable_rate, fld.peak_rate_smoothing}, 2'h3);
    chk(fld.navi_embedded, 1'b1);
    chk({fld.core_present, fld.ext_present}, 2'h3);
    chk({fld.presentation_count, fld.extension_substream_total}, {8'h1, 9'h4});
    chk(fld.hdr_size, 64'h10);
    chk({txt, 32'(n_end)}, {16'h4142, 32'h1});
    chk({fvld, err, done}, {7'h7F, 1'b0, 1'b1});
    bus(1'b0, 32'(REG_VER), 32'h0, rd);
    chk(rd, T_VER);
    bus(1'b0, 32'(REG_COUNT), 32'h0, rd);
    chk(rd, 32'h0000_0401);
    bus(1'b0, 32'(REG_STATUS), 32'h0, rd);
    chk(rd, {18'h0, STAMP_FRAME_IDX, 3'h0, 7'h7F, 2'b01});
    bus(1'b0, 32'(REG_STAMP), 32'h0, rd);
    chk(rd, T_STAMP);
    bus(1'b0, 32'(REG_RATE), 32'h0, rd);
    chk(rd, {4'h0, 5'h1F, 1'b0, 4'h5, 2'h2, RATE_HZ_2});
    bus(1'b0, 32'(REG_HSIZE), 32'h0, rd);
    chk(rd, 32'h10);
    bus(1'b0, 32'h40, 32'h0, rd);
    chk({rd, hresp}, {32'h0, 1'b0});
  endtask

  task automatic reserved_code();
    afhp_src_inst.slow = 1'b0;
    restart(32'h3);
    hdr(HDR_KEYWORD, {2'h3, 38'h0}, 8'h07, 16'h0010);
    repeat (100) if (err !== 1'b1) @(posedge clk_i);
    @(posedge clk_i);
    chk({stb_acc, fvld, done, ready_w}, {7'h60, 7'h00, 2'b00});
  endtask

  task automatic bad_key();
    restart(32'h3);
    put(HDR_KEYWORD ^ 64'h1, 8);
    put(64'h10, 8);
    repeat (100) if (err !== 1'b1) @(posedge clk_i);
    chk({stb_acc, fvld, err}, {7'h00, 7'h00, 1'b1});
  endtask

  task automatic alt_header();
    restart(32'h2);
    hdr(HDR_KEYWORD, {2'h0, 6'h0, 32'h0000_0010}, 8'h18, 16'h0008);
    repeat (10) @(posedge clk_i);
    chk({ready_w, 32'(afhp_src_inst.q.size())}, {1'b0, 32'd31});
    bus(1'b1, 32'(REG_CTRL), 32'h1, rd);
    repeat (100) if (stb_acc.ext !== 1'b1) @(posedge clk_i);
    chk({fld.reference_rate_code, fld.rate_hz}, {2'h0, RATE_HZ_0});
    chk({fld.timecode_rate_code, fld.tc_rate_rsvd}, {4'h8, 1'b1});
    chk({fld.core_present, fld.ext_present, fld.variable_rate}, 3'h4);
    chk({fld.extension_count_field, fld.extension_substream_total}, {8'h3, 9'h0});
    chk(fld.sample_count_stamp, 32'h10);
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    arst_n_i  = 1'b0;
    hsel      = 1'b0;
    haddr     = 32'h0;
    htrans    = 2'h0;
    hwrite    = 1'b0;
    hwdata    = 32'h0;
    clr       = 1'b0;
    stb_acc   = '0;
    txt       = 16'h0;
    n_end     = 0;
    bad_count = 0;
    n_checks  = 0;
    repeat (10) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    good_file();
    reserved_code();
    bad_key();
    alt_header();
    complete_run();
  end

  initial begin
    repeat (5000) @(posedge clk_i);
    bad_count++;
    complete_run();
  end
endmodule
